// File: ieb_regs.svh
`ifndef IEB_REGS_SVH
`define IEB_REGS_SVH

// Register indices in special purpose data memory
`define IEB_IDX_PRI_B     4'h0
`define IEB_IDX_PRI_C     4'h1
`define IEB_IDX_PRI_D     4'h2
`define IEB_IDX_GRP_ZERO  4'h3
`define IEB_IDX_GRP_TWO   4'h5
`define IEB_IDX_GRP_FIVE  4'h8

// Field layout: flags in the high nibble, enables in the low nibble
`define IEB_FLAG_LSB      3'h4
`define IEB_NIB_W         4

// Counts
`define IEB_PRI_SRC_COUNT 12
`define IEB_GRP_COUNT     6
`define IEB_GRP_EV_W      24

// Implemented nibble bits per group register
`define IEB_MASK_FULL     4'hF
`define IEB_MASK_TWO      4'h3
`define IEB_MASK_FIVE     4'h7

// Reset values
`define IEB_REG_RESET     8'h00
`define IEB_NIB_RESET     4'h0

`endif

// File: ieb_pkg.sv
package ieb_pkg;

  // Primary sources in register order: B[7..4], C[7..4], D[7..4]
  typedef enum logic [3:0] {
    IEB_SRC_ADC,
    IEB_SRC_G1,
    IEB_SRC_G0,
    IEB_SRC_G7,
    IEB_SRC_G3,
    IEB_SRC_G9,
    IEB_SRC_G8,
    IEB_SRC_G2,
    IEB_SRC_G5,
    IEB_SRC_G4,
    IEB_SRC_EXT3,
    IEB_SRC_EXT2
  } ieb_src_t;

  // Data memory write from the core
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ieb_bus_req_t;

  // Interrupt taken by the core
  typedef struct packed {
    logic     valid;
    ieb_src_t src;
  } ieb_ack_t;

endpackage

// File: ieb_group_reg.sv
`timescale 1ns/1ps
`include "ieb_regs.svh"

module ieb_group_reg #(
  parameter logic [3:0] IMPL_MASK = `IEB_MASK_FULL
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Software write
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // Source events, nibble bit 3 maps to register bit 7
  input  wire logic [3:0] event_in,
  // State
  output logic      [7:0] reg_out,
  output logic            any_out
);

  logic [3:0] flag;
  logic [3:0] enable;

  genvar k;
  generate
    for (k = 0; k < `IEB_NIB_W; k++) begin : g_bit
      if (IMPL_MASK[k]) begin : g_impl
        // Source event wins over a software write of zero
        always_ff @(posedge clock_in or negedge rst_n_in) begin
          if (!rst_n_in) begin
            flag[k] <= 1'b0;
          end else if (ce_in) begin
            if (event_in[k]) begin
              flag[k] <= 1'b1;
            end else if (wr_in) begin
              flag[k] <= wdata_in[`IEB_FLAG_LSB + k];
            end
          end
        end
        always_ff @(posedge clock_in or negedge rst_n_in) begin
          if (!rst_n_in) begin
            enable[k] <= 1'b0;
          end else if (ce_in && wr_in) begin
            enable[k] <= wdata_in[k];
          end
        end
      end else begin : g_none
        assign flag[k]   = 1'b0;
        assign enable[k] = 1'b0;
      end
    end
  endgenerate

  assign reg_out = {flag, enable};
  assign any_out = |(flag & enable);

  flag_sticky_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (|flag) && !wr_in |=> (flag & $past(flag)) == $past(flag))
    else $error("group flag cleared without a write");

  flag_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && |(event_in & IMPL_MASK) |=> (flag & $past(event_in & IMPL_MASK)) != 4'h0)
    else $error("group event did not set its flag");

  unimpl_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ((flag | enable) & ~IMPL_MASK) == 4'h0)
    else $error("unimplemented group bit is set");

endmodule

// File: ieb_top.sv
`timescale 1ns/1ps
`include "ieb_regs.svh"
// Behaviour
// - Register B: adc, group 1, 0, 7 flags high; matching enables low.
// - Register C: groups 3, 9, 8, 2 flags high; matching enables low.
// - Register D: groups 5, 4, pin 3, pin 2 flags high; enables low.
// - Group zero: standard and periodic timer 0 compare flags and enables.
// - Group one: same layout for standard and periodic timer 1.
// - Group two: periodic timer 2 only, bits 5,4 and 1,0; others zero.
// - Group four: standard timer 2 and periodic timer 3 compare flags, enables.
// - Group five: uart 2,1,0 flags bits 6..4, enables 2..0; rest zero.
// - Flag reads one while a request is pending; software reads and writes it.
// - Enable one lets its source through; software reads and writes it.
// - A pending flag requests an interrupt only while its enable is set.
// - Global enable low suppresses every interrupt request.
// - Taking an interrupt clears global enable; new requests still latch.
module ieb_top (
  // Clock, reset, enable
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  // Core data memory access
  input  wire ieb_pkg::ieb_bus_req_t bus_in,
  output logic                 [7:0] rdata_out,
  // Global enable write from the core and interrupt taken
  input  wire logic                  gie_wr_in,
  input  wire logic                  gie_wdata_in,
  input  wire ieb_pkg::ieb_ack_t     ack_in,
  // Event sources, one-cycle pulses on this clock
  input  wire logic                  adc_event_in,
  input  wire logic                  ext_pin2_event_in,
  input  wire logic                  ext_pin3_event_in,
  input  wire logic            [2:0] group_hi_req_in,
  input  wire logic            [`IEB_GRP_EV_W-1:0] group_event_in,
  // Requests to the core
  output logic                       global_irq_enable_out,
  output logic                       irq_request_out,
  output logic [`IEB_PRI_SRC_COUNT-1:0] pending_enabled_out
);
  import ieb_pkg::*;

  localparam int NSRC = `IEB_PRI_SRC_COUNT;

  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] enable;
  logic [NSRC-1:0] raise;
  logic            global_irq_enable;
  logic [7:0]      grp_reg [`IEB_GRP_COUNT];
  logic [`IEB_GRP_COUNT-1:0] grp_any;
  logic [7:0]      pri_reg [3];
  logic [7:0]      next_rdata;

  // Group registers zero to five
  genvar g;
  generate
    for (g = 0; g < `IEB_GRP_COUNT; g++) begin : g_grp
      localparam logic [3:0] MASK = (g == 2) ? `IEB_MASK_TWO :
                                    (g == 5) ? `IEB_MASK_FIVE : `IEB_MASK_FULL;
      ieb_group_reg #(
        .IMPL_MASK (MASK)
      ) u_grp (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .wr_in    (bus_in.wr && bus_in.addr == 4'(`IEB_IDX_GRP_ZERO + g)),
        .wdata_in (bus_in.wdata),
        .event_in (group_event_in[4*g +: 4]),
        .reg_out  (grp_reg[g]),
        .any_out  (grp_any[g])
      );
    end
  endgenerate

  // Raise sources for the primary flags
  always_comb begin
    raise               = '0;
    raise[IEB_SRC_ADC]  = adc_event_in;
    raise[IEB_SRC_EXT2] = ext_pin2_event_in;
    raise[IEB_SRC_EXT3] = ext_pin3_event_in;
    raise[IEB_SRC_G0]   = grp_any[0];
    raise[IEB_SRC_G1]   = grp_any[1];
    raise[IEB_SRC_G2]   = grp_any[2];
    raise[IEB_SRC_G3]   = grp_any[3];
    raise[IEB_SRC_G4]   = grp_any[4];
    raise[IEB_SRC_G5]   = grp_any[5];
    raise[IEB_SRC_G7]   = group_hi_req_in[0];
    raise[IEB_SRC_G8]   = group_hi_req_in[1];
    raise[IEB_SRC_G9]   = group_hi_req_in[2];
  end

  // Primary flags: source i sits in register i/4, nibble bit 3 - i%4
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_pri
      localparam int NB = 3 - (i % 4);
      logic hit;
      assign hit = bus_in.wr && bus_in.addr == 4'(`IEB_IDX_PRI_B + i / 4);
      // Raise beats both a software clear and the clear on vectoring
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pending[i] <= 1'b0;
        end else if (ce_in) begin
          if (raise[i]) begin
            pending[i] <= 1'b1;
          end else if (hit) begin
            pending[i] <= bus_in.wdata[`IEB_FLAG_LSB + NB];
          end else if (ack_in.valid && ack_in.src == ieb_src_t'(i)) begin
            pending[i] <= 1'b0;
          end
        end
      end
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          enable[i] <= 1'b0;
        end else if (ce_in && hit) begin
          enable[i] <= bus_in.wdata[NB];
        end
      end
      assign pri_reg[i / 4][`IEB_FLAG_LSB + NB] = pending[i];
      assign pri_reg[i / 4][NB]                 = enable[i];
    end
  endgenerate

  // Global enable; vectoring clears it so nesting needs a software set
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      global_irq_enable <= 1'b0;
    end else if (ce_in) begin
      if (ack_in.valid) begin
        global_irq_enable <= 1'b0;
      end else if (gie_wr_in) begin
        global_irq_enable <= gie_wdata_in;
      end
    end
  end

  // Request outputs, registered
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_request_out       <= 1'b0;
      pending_enabled_out   <= '0;
      global_irq_enable_out <= 1'b0;
    end else if (ce_in) begin
      irq_request_out       <= global_irq_enable && !ack_in.valid
                               && |(pending & enable);
      pending_enabled_out   <= pending & enable;
      global_irq_enable_out <= global_irq_enable && !ack_in.valid;
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    next_rdata = `IEB_REG_RESET;
    if (bus_in.addr < `IEB_IDX_GRP_ZERO) begin
      next_rdata = pri_reg[bus_in.addr[1:0]];
    end else if (bus_in.addr <= `IEB_IDX_GRP_FIVE) begin
      next_rdata = grp_reg[3'(bus_in.addr - `IEB_IDX_GRP_ZERO)];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= `IEB_REG_RESET;
    end else if (ce_in) begin
      rdata_out <= next_rdata;
    end
  end

  adc_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && adc_event_in |=> pending[IEB_SRC_ADC])
    else $error("adc event did not set its flag");

  summary_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && grp_any[0] |=> pending[IEB_SRC_G0] ##1 !ce_in || pending[IEB_SRC_G0]
      || $past(bus_in.wr) || $past(ack_in.valid))
    else $error("group zero summary flag not set");

  enable_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && bus_in.wr && bus_in.addr == `IEB_IDX_PRI_B
      |=> enable[IEB_SRC_ADC] == $past(bus_in.wdata[3]) && enable[IEB_SRC_G7] == $past(bus_in.wdata[0]))
    else $error("register B enable write lost");

  gie_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && ack_in.valid |=> !global_irq_enable ##1 !irq_request_out || !ce_in)
    else $error("global enable not cleared on vectoring");

  gie_block_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && !global_irq_enable |=> !irq_request_out)
    else $error("request raised with global enable low");

  mask_block_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && (pending & enable) == '0 |=> !irq_request_out && pending_enabled_out == '0)
    else $error("request raised with nothing enabled");

  req_raise_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && global_irq_enable && !ack_in.valid && |(pending & enable) |=> irq_request_out)
    else $error("enabled pending source not requested");

  grp_two_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && bus_in.addr == `IEB_IDX_GRP_TWO |=> (rdata_out & 8'hCC) == 8'h00)
    else $error("group two unimplemented bits read nonzero");

  grp_five_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && bus_in.addr == `IEB_IDX_GRP_FIVE |=> (rdata_out & 8'h88) == 8'h00)
    else $error("group five unimplemented bits read nonzero");

  reset_clear_a: assert property (@(posedge clock_in)
    $rose(rst_n_in) |-> pending == '0 && enable == '0 && !global_irq_enable)
    else $error("state not cleared by reset");

  // Requests must still latch while vectoring holds the global enable low
  late_latch_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && !global_irq_enable && ext_pin2_event_in |=> pending[IEB_SRC_EXT2])
    else $error("request lost while global enable low");

  summary_map_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ce_in && grp_any[3] |=> pending[IEB_SRC_G3])
    else $error("group three summary flag not set");

endmodule

// File: ieb_core_model.sv
`timescale 1ns/1ps
module ieb_core_model (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  // Request from the block, service delay in cycles
  input  wire logic              irq_request_in,
  input  wire logic       [11:0] pending_in,
  input  wire logic        [3:0] delay_in,
  // Interrupt taken
  output ieb_pkg::ieb_ack_t      ack_out
);
  import ieb_pkg::*;
  int k;
  initial ack_out = '{valid: 1'b0, src: IEB_SRC_ADC};
  always begin
    @(negedge clock_in);
    if (rst_n_in && irq_request_in) begin
      repeat (delay_in) @(negedge clock_in);
      // Lowest index taken first
      k = 0;
      while (k < 11 && !pending_in[k]) k++;
      ack_out.src   = ieb_src_t'(k[3:0]);
      ack_out.valid = 1'b1;
      @(negedge clock_in);
      // Released source field changes so a stale value never looks valid
      ack_out.valid = 1'b0;
      ack_out.src   = ieb_src_t'(~k[3:0]);
      repeat (2) @(negedge clock_in);
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import ieb_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} ieb_row_t;
  ieb_row_t     rows[33];
  logic [7:0]   pats[3]  = '{8'hA5, 8'h5A, 8'h00};
  logic [3:0]   eaddr[6] = '{4'h0, 4'h2, 4'h2, 4'h0, 4'h1, 4'h1};
  logic [7:0]   evals[6] = '{8'h80, 8'h10, 8'h20, 8'h10, 8'h20, 8'h40};
  logic [3:0]   saddr[6] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2};
  logic [7:0]   svals[6] = '{8'h20, 8'h40, 8'h10, 8'h80, 8'h40, 8'h80};
  logic         clock_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic         ce_in    = 1'b1;
  ieb_bus_req_t bus_in   = '0;
  logic         gie_wr_in = 1'b0;
  logic         gie_wdata_in = 1'b0;
  logic [29:0]  ev       = '0;
  logic [3:0]   delay    = 4'h0;
  logic [3:0]   ea;
  logic [7:0]   ee;
  ieb_ack_t     ack_in;
  logic [7:0]   rdata_out;
  logic         global_irq_enable_out;
  logic         irq_request_out;
  logic [11:0]  pending_enabled_out;
  int           errors   = 0;
  int           n_checks = 0;
  int           i;

  always #10 clock_in = ~clock_in;

  ieb_top uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .gie_wr_in(gie_wr_in), .gie_wdata_in(gie_wdata_in),
    .ack_in(ack_in), .adc_event_in(ev[24]), .ext_pin2_event_in(ev[25]),
    .ext_pin3_event_in(ev[26]), .group_hi_req_in(ev[29:27]), .group_event_in(ev[23:0]),
    .global_irq_enable_out(global_irq_enable_out), .irq_request_out(irq_request_out),
    .pending_enabled_out(pending_enabled_out));

  ieb_core_model core (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .irq_request_in(irq_request_out), .pending_in(pending_enabled_out),
    .delay_in(delay), .ack_out(ack_in));

  function automatic logic [7:0] msk(input logic [3:0] a);
    if (a == 4'h5) return 8'h33;
    if (a == 4'h8) return 8'h77;
    return (a < 4'h9) ? 8'hFF : 8'h00;
  endfunction

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock_in);
    bus_in = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clock_in);
    bus_in.wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clock_in);
    bus_in.addr = a;
    @(negedge clock_in);
    chk("rdata", {4'h0, e}, {4'h0, rdata_out});
  endtask

  task automatic gie(input logic v);
    @(negedge clock_in);
    gie_wr_in    = 1'b1;
    gie_wdata_in = v;
    @(negedge clock_in);
    gie_wr_in    = 1'b0;
  endtask

  task automatic pulse(input int b);
    @(negedge clock_in);
    ev[b] = 1'b1;
    @(negedge clock_in);
    ev[b] = 1'b0;
  endtask

  // Bounded wait on the request line; running out ends the run
  task automatic wait_irq(input logic lvl);
    for (int j = 0; j < 10 && irq_request_out !== lvl; j++) @(negedge clock_in);
    chk("irq_request", {11'h0, lvl}, {11'h0, irq_request_out});
    if (irq_request_out !== lvl) give_verdict();
  endtask

  initial begin
    for (i = 0; i < 33; i++) begin
      rows[i].a = (i < 30) ? 4'(i / 3) : 4'hF;
      rows[i].d = pats[i % 3];
      rows[i].e = rows[i].d & msk(rows[i].a);
    end
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    for (i = 0; i < 9; i++) rd(4'(i), 8'h00);
    for (i = 0; i < 33; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    for (i = 0; i < 30; i++) begin
      pulse(i);
      ea = (i < 24) ? 4'(3 + i / 4) : eaddr[i-24];
      ee = (i < 24) ? (8'h10 << (i % 4)) & msk(ea) : evals[i-24];
      rd(ea, ee);
      wr(ea, 8'h00);
    end
    // Each group summary must land in its own primary flag bit
    for (i = 0; i < 6; i++) begin
      wr(4'(3 + i), 8'h01);
      pulse(4 * i);
      rd(saddr[i], svals[i]);
      wr(4'(3 + i), 8'h00);
      wr(saddr[i], 8'h00);
    end
    // Frozen clock enable must drop the write
    ce_in = 1'b0;
    wr(4'h3, 8'hFF);
    ce_in = 1'b1;
    rd(4'h3, 8'h00);
    wr(4'h3, 8'h08);
    wr(4'h0, 8'h02);
    gie(1'b1);
    pulse(3);
    wait_irq(1'b1);
    chk("pending", 12'h001 << IEB_SRC_G0, pending_enabled_out);
    wait_irq(1'b0);
    chk("gie", 12'h000, {11'h0, global_irq_enable_out});
    rd(4'h3, 8'h88);
    rd(4'h0, 8'h22);
    chk("pending", 12'h001 << IEB_SRC_G0, pending_enabled_out);
    chk("irq", 12'h000, {11'h0, irq_request_out});
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h00);
    delay = 4'h3;
    pulse(24);
    gie(1'b1);
    repeat (4) @(negedge clock_in);
    chk("gie", 12'h001, {11'h0, global_irq_enable_out});
    chk("irq", 12'h000, {11'h0, irq_request_out});
    rd(4'h0, 8'h80);
    wr(4'h0, 8'h88);
    wait_irq(1'b1);
    wait_irq(1'b0);
    rd(4'h0, 8'h08);
    pulse(25);
    rd(4'h2, 8'h10);
    wr(4'h4, 8'hA5);
    @(negedge clock_in);
    rst_n_in = 1'b0;
    @(negedge clock_in);
    rst_n_in = 1'b1;
    rd(4'h4, 8'h00);
    rd(4'h2, 8'h00);
    give_verdict();
  end
endmodule
